// >>> hdl/potc_fifo.sv
`timescale 1ns/1ns
`default_nettype none
module potc_fifo
  import potc_pkg::*;
#(
  parameter int W = LEVELS,
  parameter int D = FIFO_DEPTH
)
(
  input wire logic clk,
  input wire logic rst_n,
  potc_stream_if.snk wr,
  potc_stream_if.src rd
);
  localparam int AW = $clog2(D);
  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic full;
    logic empty;
  } potc_fifo_s;
  potc_fifo_s st;
  potc_fifo_s next_st;
  // ----------------------------------------------------------------
  // Pointers, count and registered flags
  // ----------------------------------------------------------------
  always_comb
  begin
    logic push;
    logic pop;
    push = wr.valid && !st.full;
    pop = rd.ready && !st.empty;
    next_st = st;
    if (push)
    begin
      next_st.mem[st.wp] = wr.data;
      next_st.wp = (st.wp == AW'(D - 1)) ? '0 : st.wp + 1'b1;
    end
    if (pop)
    begin
      next_st.rp = (st.rp == AW'(D - 1)) ? '0 : st.rp + 1'b1;
    end
    next_st.cnt = st.cnt + (AW + 1)'(push) - (AW + 1)'(pop);
    next_st.full = (next_st.cnt == (AW + 1)'(D));
    next_st.empty = (next_st.cnt == '0);
  end
  // State register
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st <= '0;
      st.empty <= 1'b1;
    end
    else
    begin
      st <= next_st;
    end
  end
  assign wr.ready = !st.full;
  assign rd.valid = !st.empty;
  assign rd.data = st.mem[st.rp];
endmodule
`default_nettype wire

// >>> hdl/potc_pkg.sv
//
// Behaviour
// RQ1: Level drivers fire only where storage stage set
// RQ2: Feed driver fires on every output transfer
// RQ3: Punch contact cycles 16.7 ms, 2 open
// RQ4: One debounced trigger per contact closure
// RQ5: Guard 3 ms, or 2 ms if pending
// RQ6: Pending set mid-run ends guard early
// RQ7: Guard expiry with pending sets transfer latch
// RQ8: Guard expiry without pending skips this cycle
// RQ9: Storage load sets the pending latch
// RQ10: Drivers hold until contact opens
// RQ11: Transfer latch starts 0.5 ms release delay
// RQ12: Release clears storage, pending and transfer
// RQ13: Eight indicators follow the eight drivers
// RQ14: Source sends at most 3500 combinations/minute
// RQ15: Punch idles about once per forty combinations
// RQ16: Transfer pulse loads set stages, sets pending
// RQ17: Stage set needs receive stage and pulse
// RQ18: Timers are down-counters with parameter reloads; the debounce counter counts up from zero instead
// RQ19: Contact synchronised, debounce is a parameter
package potc_pkg;
  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int GUARD_LONG_NS = 3000000;
  localparam int GUARD_SHORT_NS = 2000000;
  localparam int RELEASE_NS = 500000;
  localparam int DEBOUNCE_NS = 100000;
  localparam int GUARD_LONG_CYC = GUARD_LONG_NS / CLK_PERIOD_NS;
  localparam int GUARD_SHORT_CYC = GUARD_SHORT_NS / CLK_PERIOD_NS;
  localparam int RELEASE_CYC = RELEASE_NS / CLK_PERIOD_NS;
  localparam int DEBOUNCE_CYC = DEBOUNCE_NS / CLK_PERIOD_NS;
  // ----------------------------------------------------------------
  // Data path
  // ----------------------------------------------------------------
  localparam int LEVELS = 7;
  localparam int FIFO_DEPTH = 4;
  localparam int QUICK_SHIFT = 2;
  localparam int SYNC_LAST = 2;
endpackage

// >>> hdl/potc_stream_if.sv
`timescale 1ns/1ns
`default_nettype none
// Valid/ready word stream between the buffer and its users
interface potc_stream_if #(parameter int W = 7);
  logic [W-1:0] data;
  logic valid;
  logic ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface
`default_nettype wire

// >>> hdl/potc_top.sv
`timescale 1ns/1ns
`default_nettype none
module potc_top
  import potc_pkg::*;
#(
  parameter int GUARD_LONG = GUARD_LONG_CYC,
  parameter int GUARD_SHORT = GUARD_SHORT_CYC,
  parameter int RELEASE = RELEASE_CYC,
  parameter int DEBOUNCE = DEBOUNCE_CYC,
  parameter int DEPTH = FIFO_DEPTH
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic contact,
  input wire logic [LEVELS-1:0] recv_level,
  input wire logic storage_xfer,
  output logic store_ready,
  output logic [LEVELS-1:0] level_out,
  output logic feed_out,
  output logic [LEVELS:0] indicator,
  output logic pending,
  output logic store_release
);
  localparam int TW = $clog2(GUARD_LONG + 1);
  localparam int RW = $clog2(RELEASE + 1);
  localparam int DW = $clog2(DEBOUNCE + 1);
  typedef struct packed {
    logic [SYNC_LAST:0] sync;
    logic deb;
    logic [DW-1:0] deb_cnt;
    logic trig;
    logic open;
    logic run;
    logic start_pend;
    logic [TW-1:0] tmr;
    logic [LEVELS-1:0] store;
    logic pend;
    logic xfer;
    logic rel_run;
    logic [RW-1:0] rel_tmr;
    logic rel;
    logic in_ready;
    logic [LEVELS-1:0] lvl;
    logic feed;
    logic [LEVELS:0] ind;
  } potc_top_s;
  potc_top_s st;
  potc_top_s next_st;
  logic expire;
  logic load;
  potc_stream_if #(.W(LEVELS)) in_s ();
  potc_stream_if #(.W(LEVELS)) out_s ();
  // ----------------------------------------------------------------
  // Buffer between storage transfer and the storage stages
  // ----------------------------------------------------------------
  // Receive stages captured only on a transfer pulse (see RQ17)
  assign in_s.data = recv_level;
  assign in_s.valid = storage_xfer;
  // Storage takes the next word only while idle (see RQ16)
  assign load = out_s.valid && !st.pend && !st.xfer;
  assign out_s.ready = load;
  assign expire = st.run && (st.tmr == TW'(1));
  potc_fifo #(.W(LEVELS), .D(DEPTH)) u_fifo (
    .clk(clk),
    .rst_n(rst_n),
    .wr(in_s.snk),
    .rd(out_s.src)
  );
  // ----------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    next_st.trig = 1'b0;
    next_st.open = 1'b0;
    next_st.rel = 1'b0;
    next_st.in_ready = in_s.ready;
    // Three-stage synchroniser on the contact pin (see RQ19)
    next_st.sync = {st.sync[SYNC_LAST-1:0], contact};
    // Debounce: change accepted after a stable interval (see RQ4)
    if ((st.sync[2] == st.sync[1]) && (st.sync[2] != st.deb))
    begin
      if (st.deb_cnt == DW'(DEBOUNCE - 1))
      begin
        next_st.deb = st.sync[2];
        next_st.deb_cnt = '0;
        next_st.trig = st.sync[2];
        next_st.open = !st.sync[2];
      end
      else
      begin
        next_st.deb_cnt = st.deb_cnt + 1'b1;
      end
    end
    else
    begin
      next_st.deb_cnt = '0;
    end
    // Guard down-counter, reload picked by pending (see RQ5, RQ18)
    if (st.trig)
    begin
      next_st.run = 1'b1;
      next_st.start_pend = st.pend || load;
      next_st.tmr = (st.pend || load) ? TW'(GUARD_SHORT) : TW'(GUARD_LONG);
    end
    else if (expire)
    begin
      next_st.run = 1'b0;
      next_st.tmr = '0;
    end
    else if (st.run)
    begin
      next_st.tmr = st.tmr - 1'b1;
      // Pending arriving mid-run shortens the guard (see RQ6)
      if (load && !st.start_pend)
      begin
        next_st.start_pend = 1'b1;
        if (st.tmr > TW'(GUARD_LONG - GUARD_SHORT + 1))
        begin
          next_st.tmr = st.tmr - TW'(GUARD_LONG - GUARD_SHORT + 1);
        end
        else if ((st.tmr >> QUICK_SHIFT) > TW'(1))
        begin
          next_st.tmr = st.tmr >> QUICK_SHIFT;
        end
        else
        begin
          next_st.tmr = TW'(1);
        end
      end
    end
    // Storage load copies the buffer word into the stages and sets the pending latch (see RQ9, RQ16)
    if (load)
    begin
      next_st.store = out_s.data;
      next_st.pend = 1'b1;
    end
    // Contact opening drops all drivers unless a transfer fires in the same cycle (see RQ10)
    if (st.open)
    begin
      next_st.lvl = '0;
      next_st.feed = 1'b0;
    end
    // Expiry with pending fires the transfer; without, skip (see RQ7, RQ8, RQ15)
    if (expire && st.pend && !st.xfer)
    begin
      next_st.xfer = 1'b1;
      next_st.lvl = st.store; // see RQ1
      next_st.feed = 1'b1; // see RQ2
      next_st.rel_run = 1'b1; // see RQ11
      next_st.rel_tmr = RW'(RELEASE);
    end
    // Release delay down-counter (see RQ11, RQ18)
    if (st.rel_run)
    begin
      if (st.rel_tmr == RW'(1))
      begin
        next_st.rel_run = 1'b0;
        next_st.rel_tmr = '0;
        next_st.rel = 1'b1;
        // Release empties storage and both latches (see RQ12)
        next_st.store = '0;
        next_st.pend = 1'b0;
        next_st.xfer = 1'b0;
      end
      else
      begin
        next_st.rel_tmr = st.rel_tmr - 1'b1;
      end
    end
    // Indicators mirror the drivers (see RQ13)
    next_st.ind = {next_st.feed, next_st.lvl};
  end
  // State register
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end
  // Outputs
  assign store_ready = st.in_ready;
  assign level_out = st.lvl;
  assign feed_out = st.feed;
  assign indicator = st.ind;
  assign pending = st.pend;
  assign store_release = st.rel;
  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Cycles since the last trigger and since the last transfer
  // Pending state seen when the guard last started
  int g_el;
  int r_el;
  logic pend_at_trig;
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      g_el <= 0;
      r_el <= 0;
      pend_at_trig <= 1'b0;
    end
    else
    begin
      g_el <= st.trig ? 0 : g_el + 1;
      r_el <= (!st.xfer) ? 0 : r_el + 1;
      pend_at_trig <= st.trig ? st.pend : pend_at_trig;
    end
  end
  property p_levels;
    @(posedge clk) disable iff (!rst_n)
    $rose(st.xfer) |-> (level_out == $past(st.store));
  endproperty
  a_levels: assert property (p_levels) else $error("level drivers differ from storage"); // see RQ1
  property p_feed;
    @(posedge clk) disable iff (!rst_n)
    $rose(st.xfer) |-> feed_out && (indicator[LEVELS] == 1'b1);
  endproperty
  a_feed: assert property (p_feed) else $error("feed driver missing on transfer"); // see RQ2
  property p_one_trig;
    @(posedge clk) disable iff (!rst_n)
    st.trig |=> !st.trig [*8];
  endproperty
  a_one_trig: assert property (p_one_trig) else $error("contact closure retriggered"); // see RQ4
  property p_short_guard;
    @(posedge clk) disable iff (!rst_n)
    (expire && pend_at_trig && !st.trig) |-> (g_el == GUARD_SHORT - 1);
  endproperty
  a_short_guard: assert property (p_short_guard) else $error("guard too long"); // see RQ5
  // Pending arriving mid-run ends the guard between short and long
  property p_mid_guard;
    @(posedge clk) disable iff (!rst_n)
    (expire && st.start_pend && !pend_at_trig && !st.trig) |->
      (g_el >= GUARD_SHORT - 1) && (g_el <= GUARD_LONG - 1);
  endproperty
  a_mid_guard: assert property (p_mid_guard) else $error("early expiry out of range"); // see RQ6
  property p_long_guard;
    @(posedge clk) disable iff (!rst_n)
    (expire && !st.start_pend) |-> (g_el == GUARD_LONG - 1);
  endproperty
  a_long_guard: assert property (p_long_guard) else $error("guard not 3 ms"); // see RQ5
  property p_fire;
    @(posedge clk) disable iff (!rst_n)
    (expire && st.pend && !st.xfer) |=> st.xfer && st.rel_run;
  endproperty
  a_fire: assert property (p_fire) else $error("transfer latch not set"); // see RQ7
  property p_skip;
    @(posedge clk) disable iff (!rst_n)
    (expire && !st.pend && !st.xfer) |=> !st.xfer;
  endproperty
  a_skip: assert property (p_skip) else $error("transfer without pending"); // see RQ8
  property p_drop;
    @(posedge clk) disable iff (!rst_n)
    (st.open && !(expire && st.pend)) |=> !feed_out && (level_out == '0);
  endproperty
  a_drop: assert property (p_drop) else $error("drivers held past opening"); // see RQ10
  property p_release;
    @(posedge clk) disable iff (!rst_n)
    st.rel |-> (r_el == RELEASE);
  endproperty
  a_release: assert property (p_release) else $error("release delay wrong"); // see RQ11
  property p_clear;
    @(posedge clk) disable iff (!rst_n)
    st.rel |-> !st.pend && !st.xfer && (st.store == '0);
  endproperty
  a_clear: assert property (p_clear) else $error("release left state"); // see RQ12
  property p_pend;
    @(posedge clk) disable iff (!rst_n)
    load |=> pending;
  endproperty
  a_pend: assert property (p_pend) else $error("load did not set pending"); // see RQ9
  // Driver, indicator and storage gating
  property p_indicator;
    @(posedge clk) disable iff (!rst_n)
    indicator == {feed_out, level_out};
  endproperty
  a_indicator: assert property (p_indicator) else $error("indicator differs from driver"); // see RQ13
  property p_level_gate;
    @(posedge clk) disable iff (!rst_n)
    !feed_out |-> (level_out == '0);
  endproperty
  a_level_gate: assert property (p_level_gate) else $error("level driver without transfer"); // see RQ1
  property p_store_gate;
    @(posedge clk) disable iff (!rst_n)
    !load |=> ((st.store & ~$past(st.store)) == '0);
  endproperty
  a_store_gate: assert property (p_store_gate) else $error("storage set without transfer"); // see RQ17
  property p_rel_pulse;
    @(posedge clk) disable iff (!rst_n)
    store_release |=> !store_release;
  endproperty
  a_rel_pulse: assert property (p_rel_pulse) else $error("release pulse too long"); // see RQ11
  property p_deb_sync;
    @(posedge clk) disable iff (!rst_n)
    st.trig |-> ($past(st.sync[2]) && $past(st.sync[1]));
  endproperty
  a_deb_sync: assert property (p_deb_sync) else $error("trigger without settled contact"); // see RQ19
endmodule
`default_nettype wire

// >>> tb/potc_punch_model.sv
`timescale 1ns/1ns
`default_nettype none
module potc_punch_model
  import potc_pkg::*;
#(
  parameter int CLOSED = 294,
  parameter int OPEN = 40
)
(
  input wire logic clk,
  input wire logic go,
  input wire logic feed_out,
  output logic contact,
  output int punched
);
  // ----
  // Punch cycle
  // ----
  int c = -1;
  logic feed_q = 1'b0;
  initial punched = 0;
  // One closed then open period per go, contact rests open between
  always @(posedge clk)
  begin
    if (go)
      c <= 0;
    else if (c >= 0 && c < CLOSED + OPEN - 1)
      c <= c + 1;
    else
      c <= -1;
    feed_q <= feed_out;
    if (feed_out && !feed_q)
      punched <= punched + 1;
  end
  // Closed with one bounce at its start
  assign contact = (c >= 0) && (c < CLOSED) && (c != 1);
endmodule
`default_nettype wire

// >>> tb/tb.sv
`timescale 1ns/1ns
`default_nettype none
module tb
  import potc_pkg::*;
;
  // ----
  // Bench signals
  // ----
  localparam int GS = 40;
  localparam int RL = 10;
  localparam int CL = 294;
  localparam int OP = 40;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic go = 1'b0;
  logic storage_xfer = 1'b0;
  logic [LEVELS-1:0] recv_level = '0;
  logic contact, store_ready, feed_out, pending, store_release;
  logic [LEVELS-1:0] level_out;
  logic [LEVELS:0] indicator;
  int punched;
  int err_total = 0;
  int n_compared = 0;
  // Clock of 50 ns
  always #25 clk = ~clk;
  potc_top #(.GUARD_LONG(60), .GUARD_SHORT(GS), .RELEASE(RL), .DEBOUNCE(4)) potc_top_i (
    .clk(clk), .rst_n(rst_n), .contact(contact), .recv_level(recv_level),
    .storage_xfer(storage_xfer), .store_ready(store_ready), .level_out(level_out),
    .feed_out(feed_out), .indicator(indicator), .pending(pending),
    .store_release(store_release));
  potc_punch_model #(.CLOSED(CL), .OPEN(OP)) potc_punch_model_i (
    .clk(clk), .go(go), .feed_out(feed_out), .contact(contact), .punched(punched));
  // ----
  // Helpers
  // ----
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic give_verdict();
    if (err_total == 0 && n_compared > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // One word into the buffer, then an idle cycle
  task automatic push(input logic [6:0] w);
    storage_xfer = 1'b1;
    recv_level = w;
    @(posedge clk);
    #2 storage_xfer = 1'b0;
    @(posedge clk);
    #2;
  endtask
  // One punch period, optional push at a given cycle, judged on the way
  task automatic punch(input bit want, input logic [6:0] w, input int push_at);
    int tf;
    int tr;
    int lo;
    int hi;
    tf = -1;
    tr = -1;
    lo = (push_at < 0) ? GS : push_at;
    hi = (push_at < 0) ? GS + 20 : push_at + 15;
    for (int c = 0; c < CL + OP + 4; c++)
    begin
      go = (c == 0);
      storage_xfer = (c == push_at);
      recv_level = w;
      @(posedge clk);
      #2;
      if (feed_out === 1'b1 && tf < 0)
      begin
        tf = c;
        chk("indicator", {1'b1, w}, indicator);
      end
      if (store_release === 1'b1 && tr < 0)
      begin
        tr = c;
        chk("pending at release", 8'h00, {7'h00, pending});
      end
      if (c == CL - 1 && want)
        chk("drivers held", {1'b1, w}, {feed_out, level_out});
    end
    chk("drivers after opening", 8'h00, {feed_out, level_out});
    chk("transfer", {7'h00, want}, {7'h00, tf >= 0});
    if (want)
    begin
      chk("guard span", 8'h01, {7'h00, tf >= lo && tf <= hi});
      chk("release delay", 8'h01, {7'h00, tr - tf >= RL - 2 && tr - tf <= RL + 3});
    end
  endtask
  // ----
  // Scenarios
  // ----
  task automatic t_ready();
    push(7'h55);
    @(posedge clk);
    #2;
    chk("pending after load", 8'h01, {7'h00, pending});
    punch(1'b1, 7'h55, -1);
  endtask
  task automatic t_idle();
    punch(1'b0, 7'h00, -1);
  endtask
  task automatic t_mid();
    punch(1'b1, 7'h2A, 50);
  endtask
  task automatic t_late();
    punch(1'b0, 7'h11, 90);
    chk("word waits", 8'h01, {7'h00, pending});
    punch(1'b1, 7'h11, -1);
  endtask
  task automatic t_fifo();
    logic [6:0] w [5] = '{7'h7F, 7'h00, 7'h01, 7'h40, 7'h3C};
    foreach (w[i])
      push(w[i]);
    chk("buffer full", 8'h00, {7'h00, store_ready});
    push(7'h22);
    foreach (w[i])
      punch(1'b1, w[i], -1);
    punch(1'b0, 7'h22, -1);
    chk("buffer drained", 8'h01, {7'h00, store_ready});
  endtask
  // ----
  // Main sequence and watchdog
  // ----
  initial
  begin
    repeat (20) @(posedge clk);
    #2 rst_n = 1'b1;
    repeat (2) @(posedge clk);
    #2;
    t_ready();
    t_idle();
    t_mid();
    t_late();
    t_fifo();
    chk("punch count", 8'h08, punched[7:0]);
    give_verdict();
  end
  // Cut a hang short
  initial
  begin
    #(20000 * 50);
    err_total++;
    give_verdict();
  end
endmodule
`default_nettype wire
